// ### design/dtbsel_defs.svh
`ifndef DTBSEL_DEFS_SVH
`define DTBSEL_DEFS_SVH

// Local clock period and the strobe settling time, both in picoseconds.
`define DTBSEL_CLK_PS     5000
`define DTBSEL_SETTLE_PS  10000
// Least settling time rounds up to whole clock cycles.
`define DTBSEL_SETTLE_CYC \
    ((`DTBSEL_SETTLE_PS + `DTBSEL_CLK_PS - 1) / `DTBSEL_CLK_PS)

// Width of the bundle of backplane inputs passed through the synchroniser.
`define DTBSEL_SYNC_W     74
`define DTBSEL_CNT_W      4

// Byte lane enables of an eight byte group and of no byte at all.
`define DTBSEL_BE_ALL     8'hff
`define DTBSEL_BE_NONE    8'h00
`define DTBSEL_NIB_NONE   4'h0

// Address masks of the narrow modes, byte address form.
`define DTBSEL_MASK_A16   64'h0000_0000_0000_fffe
`define DTBSEL_MASK_A24   64'h0000_0000_00ff_fffe
`define DTBSEL_A16_BITS   16
`define DTBSEL_A40_BITS   40

// Field slices of the data and address lines.
`define DTBSEL_D_B0       7:0
`define DTBSEL_D_B1       15:8
`define DTBSEL_D_LO16     15:0
`define DTBSEL_A_LO24     23:1
`define DTBSEL_A_LO16     15:1

`endif

// ### design/dtbsel_pkg.sv
package dtbsel_pkg;

    // Address mode decoded from the address-modifier lines.
    typedef enum logic [2:0] {
        DTBSEL_M_NONE = 3'b000,
        DTBSEL_M_A16  = 3'b001,
        DTBSEL_M_A24  = 3'b010,
        DTBSEL_M_A32  = 3'b011,
        DTBSEL_M_A40  = 3'b100,
        DTBSEL_M_A64  = 3'b101
    } dtbsel_mode_t;

    // Slave cycle sequencer states.
    typedef enum logic [2:0] {
        DTBSEL_S_IDLE   = 3'b000,
        DTBSEL_S_STROBE = 3'b001,
        DTBSEL_S_SETTLE = 3'b010,
        DTBSEL_S_HOLD   = 3'b011,
        DTBSEL_S_TERM   = 3'b100,
        DTBSEL_S_IGNORE = 3'b101
    } dtbsel_state_t;

endpackage

// ### design/dtbsel_sel_if.sv
`timescale 1ns/1ps
// Byte select lines going to the lane decoder and its answer.
interface dtbsel_sel_if;
    logic       ds1_n;
    logic       ds0_n;
    logic       a1;
    logic       a2;
    logic       lword_n;
    logic       eight;
    logic [7:0] be;
    logic       illegal;
    logic       addr_only;

    modport host (output ds1_n, ds0_n, a1, a2, lword_n, eight,
                  input  be, illegal, addr_only);
    modport dec  (input  ds1_n, ds0_n, a1, a2, lword_n, eight,
                  output be, illegal, addr_only);
endinterface

// ### design/dtbsel_lane_dec.sv
`timescale 1ns/1ps
`include "dtbsel_defs.svh"
module dtbsel_lane_dec (
    dtbsel_sel_if.dec sel
);
    wire       lo_en;
    wire       hi_en;
    wire       any_en;
    wire [3:0] be_pair;
    wire [3:0] be_quad;
    wire [3:0] be4;
    wire       bad4;
    wire       bad8;

    // The even byte of a pair follows DS1*, the odd byte DS0*.
    assign lo_en  = ~sel.ds1_n;
    assign hi_en  = ~sel.ds0_n;
    assign any_en = lo_en | hi_en;

    // Single and double byte selects; A1 picks the half of the group.
    assign be_pair = sel.a1 ? {hi_en, lo_en, 2'b00}
                            : {2'b00, hi_en, lo_en};

    // With LWORD* low, A1 low gives quad or three byte selects, and A1
    // high is legal only with both strobes low, the middle two bytes.
    assign be_quad = sel.a1 ? {1'b0, lo_en & hi_en, lo_en & hi_en, 1'b0}
                            : {hi_en, any_en, any_en, lo_en};
    assign be4 = sel.lword_n ? be_pair : be_quad;

    // One strobe low with LWORD* low and A1 high is never a final state.
    assign bad4 = ~sel.lword_n & sel.a1 & (sel.ds1_n ^ sel.ds0_n);
    // An eight byte access needs every select line low.
    assign bad8 = sel.ds1_n | sel.ds0_n | sel.lword_n
                | sel.a1 | sel.a2;

    assign sel.addr_only = sel.ds1_n & sel.ds0_n;
    assign sel.illegal   = sel.eight ? bad8 : bad4;

    // A2 picks which half of the eight lanes the four byte group uses.
    assign sel.be = sel.eight   ? `DTBSEL_BE_ALL :
                    sel.illegal ? `DTBSEL_BE_NONE :
                    sel.a2      ? {be4, `DTBSEL_NIB_NONE}
                                : {`DTBSEL_NIB_NONE, be4};
endmodule

// ### design/dtbsel_slave.sv
`timescale 1ns/1ps
`include "dtbsel_defs.svh"
module dtbsel_slave #(
    parameter logic [5:0] AM_A16     = 6'h01, // Arbitrary code.
    parameter logic [5:0] AM_A24     = 6'h02, // Arbitrary code.
    parameter logic [5:0] AM_A32     = 6'h03, // Arbitrary code.
    parameter logic [5:0] AM_A40     = 6'h04, // Arbitrary code.
    parameter logic [5:0] AM_A64     = 6'h05, // Arbitrary code.
    parameter logic [5:0] AM_MBLT    = 6'h06, // Arbitrary code.
    parameter int         SETTLE_CYC = `DTBSEL_SETTLE_CYC
) (
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    input  wire logic        AS_N_I,
    input  wire logic        DS0_N_I,
    input  wire logic        DS1_N_I,
    input  wire logic        LWORD_N_I,
    input  wire logic        WRITE_N_I,
    input  wire logic [5:0]  AM_I,
    input  wire logic [31:1] A_I,
    input  wire logic [31:0] D_I,
    input  wire logic        ACK_I,
    input  wire logic        ERR_I,
    output logic             REQ_O,
    output logic [63:0]      ADDR_O,
    output logic [7:0]       BE_O,
    output logic [2:0]       MODE_O,
    output logic             EIGHT_O,
    output logic             WR_O,
    output logic [63:0]      DATA_O,
    output logic             DATA_VLD_O,
    output logic             ILLEGAL_O,
    output logic             DTACK_N_O,
    output logic             DTACK_OE_O,
    output logic             BERR_N_O,
    output logic             BERR_OE_O
);
    localparam int CW = `DTBSEL_CNT_W;

    dtbsel_sel_if sel ();

    logic [`DTBSEL_SYNC_W-1:0] sync1_r;
    logic [`DTBSEL_SYNC_W-1:0] sync2_r;
    logic                      as_n;
    logic                      ds1_n;
    logic                      ds0_n;
    logic                      lword_n;
    logic                      write_n;
    logic [5:0]                am;
    logic [31:1]               a;
    logic [31:0]               d;

    dtbsel_pkg::dtbsel_state_t state_r;
    dtbsel_pkg::dtbsel_state_t state_nxt;
    dtbsel_pkg::dtbsel_mode_t  mode_r;
    logic                      as_prev_r;
    logic [1:0]                ds_last_r;
    logic [CW-1:0]             cnt_r;
    logic                      eight_r;
    logic                      a1_r;
    logic                      a2_r;
    logic                      lword_r;
    logic                      first_r;
    logic                      err_r;
    logic                      wr_r;
    logic [63:0]               addr_r;
    logic [7:0]                be_r;
    logic [63:0]               data_r;
    logic                      data_vld_r;
    logic                      illegal_r;

    // Every backplane line is asynchronous to the local clock. The
    // address and modifier lines settle before the address strobe falls,
    // so sampling them together with the synchronised strobe is safe.
    always_ff @(posedge MCLK_I) begin
        sync1_r <= {AS_N_I, DS1_N_I, DS0_N_I, LWORD_N_I, WRITE_N_I,
                    AM_I, A_I, D_I};
        sync2_r <= sync1_r;
    end

    assign {as_n, ds1_n, ds0_n, lword_n, write_n, am, a, d} = sync2_r;

    // Cycle type comes only from the modifier code.
    function automatic dtbsel_pkg::dtbsel_mode_t am_mode(
        input logic [5:0] code
    );
        case (code)
            AM_A16:  am_mode = dtbsel_pkg::DTBSEL_M_A16;
            AM_A24:  am_mode = dtbsel_pkg::DTBSEL_M_A24;
            AM_A32:  am_mode = dtbsel_pkg::DTBSEL_M_A32;
            AM_MBLT: am_mode = dtbsel_pkg::DTBSEL_M_A32;
            AM_A40:  am_mode = dtbsel_pkg::DTBSEL_M_A40;
            AM_A64:  am_mode = dtbsel_pkg::DTBSEL_M_A64;
            default: am_mode = dtbsel_pkg::DTBSEL_M_NONE;
        endcase
    endfunction

    // Byte address assembled from address and data lines per mode.
    function automatic logic [63:0] addr_build(
        input dtbsel_pkg::dtbsel_mode_t m,
        input logic [31:1]              al,
        input logic [31:0]              dl
    );
        logic [63:0] lo;
        lo = {32'h0, al, 1'b0};
        case (m)
            dtbsel_pkg::DTBSEL_M_A16: addr_build = lo & `DTBSEL_MASK_A16;
            dtbsel_pkg::DTBSEL_M_A24: addr_build = lo & `DTBSEL_MASK_A24;
            dtbsel_pkg::DTBSEL_M_A32: addr_build = lo;
            dtbsel_pkg::DTBSEL_M_A40:
                addr_build = {24'h0, dl[`DTBSEL_D_B0], dl[`DTBSEL_D_B1],
                              al[`DTBSEL_A_LO24], 1'b0};
            dtbsel_pkg::DTBSEL_M_A64:
                addr_build = {dl, al, 1'b0};
            default:                  addr_build = '0;
        endcase
    endfunction

    // Named decode terms of the sequencer.
    wire as_fall     = as_prev_r & ~as_n;
    wire ds_any_low  = ~sel.addr_only; // Both strobes high is address only.
    wire ds_same     = ({ds1_n, ds0_n} == ds_last_r);
    wire settle_done = (state_r == dtbsel_pkg::DTBSEL_S_SETTLE) & ds_same
                     & ds_any_low & (cnt_r == CW'(SETTLE_CYC - 1));
    wire mode_none   = (mode_r == dtbsel_pkg::DTBSEL_M_NONE);
    wire bad_first   = settle_done & first_r & sel.illegal;
    wire mux_beat    = ~first_r & (eight_r
                     | (mode_r == dtbsel_pkg::DTBSEL_M_A40));

    // Selection lines for the lane decoder. A1, A2 and LWORD* are the
    // first-beat values; later block beats reuse them.
    assign sel.ds1_n   = ds1_n;
    assign sel.ds0_n   = ds0_n;
    assign sel.a1      = a1_r;
    assign sel.a2      = a2_r;
    assign sel.lword_n = lword_r;
    assign sel.eight   = eight_r;

    dtbsel_lane_dec u_dec (
        .sel (sel)
    );

    // Sequencer: strobe levels select, strobe edges pace each beat.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dtbsel_pkg::DTBSEL_S_IDLE:
                if (as_fall) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_STROBE;
                end
            dtbsel_pkg::DTBSEL_S_STROBE:
                if (as_n) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_IDLE;
                end else if (ds_any_low) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_SETTLE;
                end
            dtbsel_pkg::DTBSEL_S_SETTLE:
                if (as_n) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_IDLE;
                end else if (!ds_any_low) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_STROBE;
                end else if (settle_done && mode_none) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_IGNORE;
                end else if (bad_first) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_TERM;
                end else if (settle_done) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_HOLD;
                end
            dtbsel_pkg::DTBSEL_S_HOLD:
                if (as_n) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_IDLE;
                end else if (ACK_I || ERR_I) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_TERM;
                end
            dtbsel_pkg::DTBSEL_S_TERM:
                if (!ds_any_low) begin
                    state_nxt = as_n ? dtbsel_pkg::DTBSEL_S_IDLE
                                     : dtbsel_pkg::DTBSEL_S_STROBE;
                end
            dtbsel_pkg::DTBSEL_S_IGNORE:
                if (as_n) begin
                    state_nxt = dtbsel_pkg::DTBSEL_S_IDLE;
                end
            default: state_nxt = dtbsel_pkg::DTBSEL_S_IDLE;
        endcase
    end

    // State, edge history and the settling counter.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            state_r   <= dtbsel_pkg::DTBSEL_S_IDLE;
            as_prev_r <= 1'b1;
            ds_last_r <= 2'b11;
            cnt_r     <= '0;
        end else begin
            state_r   <= state_nxt;
            as_prev_r <= as_n;
            ds_last_r <= {ds1_n, ds0_n};
            cnt_r     <= (ds_same && state_r == dtbsel_pkg::DTBSEL_S_SETTLE)
                       ? cnt_r + CW'(1) : '0;
        end
    end

    // Address phase capture on the falling address strobe; held to the end.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            mode_r  <= dtbsel_pkg::DTBSEL_M_NONE;
            eight_r <= 1'b0;
            a1_r    <= 1'b0;
            a2_r    <= 1'b0;
            lword_r <= 1'b1;
            wr_r    <= 1'b0;
            addr_r  <= '0;
        end else if (state_r == dtbsel_pkg::DTBSEL_S_IDLE && as_fall) begin
            mode_r  <= am_mode(am);
            eight_r <= (am == AM_MBLT);
            a1_r    <= a[1];
            a2_r    <= a[2];
            lword_r <= lword_n;
            wr_r    <= ~write_n;
            addr_r  <= addr_build(am_mode(am), a, d);
        end
    end

    // Per-beat capture of lanes, data and error state at the settled point.
    // The first strobe beat of a multiplexed mode carries address only.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            first_r    <= 1'b1;
            err_r      <= 1'b0;
            be_r       <= `DTBSEL_BE_NONE;
            data_r     <= '0;
            data_vld_r <= 1'b0;
            illegal_r  <= 1'b0;
        end else begin
            data_vld_r <= settle_done & wr_r & ~mode_none & ~bad_first
                        & ~(first_r & (eight_r
                        | mode_r == dtbsel_pkg::DTBSEL_M_A40
                        | mode_r == dtbsel_pkg::DTBSEL_M_A64));
            if (state_r == dtbsel_pkg::DTBSEL_S_IDLE) begin
                first_r   <= 1'b1;
                illegal_r <= illegal_r & ~as_fall;
            end else if (state_r == dtbsel_pkg::DTBSEL_S_TERM
                         && !ds_any_low) begin
                first_r <= 1'b0;
            end
            if (settle_done) begin
                be_r   <= sel.be;
                err_r  <= bad_first;
                data_r <= eight_r & mux_beat ? {a, lword_n, d}
                        : mux_beat ? {32'h0, a[`DTBSEL_A_LO16], lword_n,
                                      d[`DTBSEL_D_LO16]}
                        : {32'h0, d};
            end
            if (bad_first) begin
                illegal_r <= 1'b1;
            end
            if (state_r == dtbsel_pkg::DTBSEL_S_HOLD) begin
                err_r <= ERR_I; // Error wins when both answers come.
            end
        end
    end

    // Handshake outputs follow the state directly.
    assign REQ_O      = (state_r == dtbsel_pkg::DTBSEL_S_HOLD);
    assign DTACK_OE_O = (state_r == dtbsel_pkg::DTBSEL_S_TERM) & ~err_r;
    assign BERR_OE_O  = (state_r == dtbsel_pkg::DTBSEL_S_TERM) & err_r;
    assign DTACK_N_O  = ~DTACK_OE_O;
    assign BERR_N_O   = ~BERR_OE_O;
    assign ADDR_O     = addr_r;
    assign BE_O       = be_r;
    assign MODE_O     = mode_r;
    assign EIGHT_O    = eight_r;
    assign WR_O       = wr_r;
    assign DATA_O     = data_r;
    assign DATA_VLD_O = data_vld_r;
    assign ILLEGAL_O  = illegal_r;

    // Checks on the slave side of the cycle.
    sequence s_bad_decode;
        bad_first && !mode_none;
    endsequence

    sequence s_waiting;
        REQ_O && !ACK_I && !ERR_I && !as_n;
    endsequence

    a_settled_req: assert property (@(posedge MCLK_I) disable iff (RST_I)
        $rose(REQ_O) |-> $past({ds1_n, ds0_n}, 1) ==
                         $past({ds1_n, ds0_n}, 2))
        else $error("Request raised on unsettled strobe levels.");

    a_illegal_berr: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_bad_decode |=> BERR_OE_O && !BERR_N_O && !REQ_O)
        else $error("Illegal select did not end with bus error.");

    a_req_holds: assert property (@(posedge MCLK_I) disable iff (RST_I)
        s_waiting |=> REQ_O && $stable(ADDR_O) && $stable(BE_O))
        else $error("Decoded cycle changed before it was answered.");

    a_ack_dtack: assert property (@(posedge MCLK_I) disable iff (RST_I)
        REQ_O && ACK_I && !ERR_I && !as_n
        |=> DTACK_OE_O && !DTACK_N_O && !BERR_OE_O)
        else $error("Local acknowledge did not drive DTACK.");

    a_term_release: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (DTACK_OE_O || BERR_OE_O) && ds1_n && ds0_n
        |=> !DTACK_OE_O && !BERR_OE_O)
        else $error("Termination held after strobes rose.");

    a_eight_lanes: assert property (@(posedge MCLK_I) disable iff (RST_I)
        REQ_O && EIGHT_O |-> BE_O == `DTBSEL_BE_ALL)
        else $error("Eight byte access without all lanes.");

    a_a40_range: assert property (@(posedge MCLK_I) disable iff (RST_I)
        REQ_O && MODE_O == dtbsel_pkg::DTBSEL_M_A40
        |-> (ADDR_O >> `DTBSEL_A40_BITS) == '0)
        else $error("A40 address reaches above bit 39.");

    a_a16_range: assert property (@(posedge MCLK_I) disable iff (RST_I)
        REQ_O && MODE_O == dtbsel_pkg::DTBSEL_M_A16
        |-> (ADDR_O >> `DTBSEL_A16_BITS) == '0)
        else $error("A16 address reaches above bit 15.");

endmodule

// ### tb/dtbsel_bus_mdl.sv
`timescale 1ns/1ps
// Backplane master that runs one beat at a time for the bench.
module dtbsel_bus_mdl (
    input  wire logic        clk,
    input  wire logic        dtack_oe,
    input  wire logic        berr_oe,
    output logic             as_n,
    output logic             ds0_n,
    output logic             ds1_n,
    output logic             lword_n,
    output logic             write_n,
    output logic [5:0]       am,
    output logic [31:1]      a,
    output logic [31:0]      d
);
    // The bus starts idle: strobes high and no cycle type.
    initial begin
        {as_n, ds0_n, ds1_n, lword_n, write_n} = 5'h1f;
        am = 6'h3f;
        a  = '0;
        d  = '0;
    end

    // Address phase; lines stay put until the beat has been answered.
    task automatic addr(input logic [5:0] m, input logic [31:1] ad,
                        input logic [31:0] dd, input logic lw,
                        input logic wn);
        @(posedge clk);
        #1;
        am      = m;
        a       = ad;
        d       = dd;
        lword_n = lw;
        write_n = wn;
        as_n    = 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Later block beats carry data words on the address lines too.
    task automatic put(input logic [31:1] ad, input logic [31:0] dd,
                       input logic lw);
        @(posedge clk);
        #1;
        a       = ad;
        d       = dd;
        lword_n = lw;
    endtask

    // Strobes fall; with skew the odd strobe lags by a whole cycle.
    task automatic strobe(input logic s1, input logic s0, input logic sk);
        @(posedge clk);
        #1;
        ds1_n = s1;
        ds0_n = sk ? 1'b1 : s0;
        if (sk) begin
            @(posedge clk);
            #1;
            ds0_n = s0;
        end
    endtask

    // Strobes are held until an answer is sampled or 40 cycles pass, then released; the
    // next beat waits for the answer to go, so beats never overlap.
    task automatic done(output bit ok, output bit eb);
        ok = 1'b0;
        eb = 1'b0;
        // Answers are read just after the edge that launches them, so the
        // model never races the slave's own register updates.
        for (int i = 0; i < 40 && !ok; i++) begin
            @(posedge clk);
            #1;
            ok = dtack_oe === 1'b1 || berr_oe === 1'b1;
            eb = berr_oe === 1'b1;
        end
        {ds1_n, ds0_n} = 2'b11;
        for (int i = 0; i < 20 && (dtack_oe !== 1'b0 || berr_oe !== 1'b0);
             i++) begin
            @(posedge clk);
            #1;
        end
    endtask

    // Released lines show the inverse of their last value, not a copy.
    task automatic rel_as();
        @(posedge clk);
        #1;
        as_n    = 1'b1;
        a       = ~a;
        d       = ~d;
        lword_n = ~lword_n;
        am      = ~am;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
// Self-checking bench for the backplane byte lane slave.
module tb;
    logic        mclk, rst, ack, err, as_n, ds0_n, ds1_n, lword_n, write_n;
    logic        req, eight, wr, vld, illegal;
    logic        dtack_n, dtack_oe, berr_n, berr_oe;
    logic [5:0]  am;
    logic [31:1] a;
    logic [31:0] d;
    logic [63:0] addr, data;
    logic [7:0]  be;
    logic [2:0]  mode;
    int          n_errors, checks_done;

    dtbsel_bus_mdl bus (.clk(mclk), .dtack_oe(dtack_oe), .berr_oe(berr_oe),
        .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n), .lword_n(lword_n),
        .write_n(write_n), .am(am), .a(a), .d(d));

    dtbsel_slave uut (.MCLK_I(mclk), .RST_I(rst), .AS_N_I(as_n),
        .DS0_N_I(ds0_n), .DS1_N_I(ds1_n), .LWORD_N_I(lword_n),
        .WRITE_N_I(write_n), .AM_I(am), .A_I(a), .D_I(d), .ACK_I(ack),
        .ERR_I(err), .REQ_O(req), .ADDR_O(addr), .BE_O(be), .MODE_O(mode),
        .EIGHT_O(eight), .WR_O(wr), .DATA_O(data), .DATA_VLD_O(vld),
        .ILLEGAL_O(illegal), .DTACK_N_O(dtack_n), .DTACK_OE_O(dtack_oe),
        .BERR_N_O(berr_n), .BERR_OE_O(berr_oe));

    // The 200 MHz local clock.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic finish_test();
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] exp,
                       input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Bounded wait for a decoded beat; the valid pulse is taken with it.
    task automatic wait_req(output bit ok, output logic v);
        ok = 1'b0;
        v  = 1'b0;
        for (int i = 0; i < 30 && !ok; i++) begin
            @(posedge mclk);
            #1;
            ok = req === 1'b1;
            v  = vld;
        end
    endtask

    // One answered beat; the local side accepts it or rejects it.
    task automatic beat(input logic s1, s0, sk, e, input logic [7:0] bx,
                        output logic v);
        bit ok, eb;
        bus.strobe(s1, s0, sk);
        wait_req(ok, v);
        chk("req", 64'h1, 64'(ok));
        chk("be", 64'(bx), 64'(be));
        chk("illegal", 64'h0, 64'(illegal));
        // One unanswered cycle shows that the held request stays put.
        @(posedge mclk);
        #1;
        ack = !e;
        err = e;
        bus.done(ok, eb);
        ack = 1'b0;
        err = 1'b0;
        chk("answer", 64'h1, 64'(ok));
        chk("berr", 64'(e), 64'(eb));
    endtask

    // All legal select patterns of a four byte group, in both halves of the
    // eight byte group, as A32 writes.
    task automatic t_lanes();
        logic [3:0] sel [10] = '{4'h5, 4'h7, 4'h9, 4'hb, 4'h1, 4'h3, 4'h0,
                                 4'h4, 4'h8, 4'h2};
        logic [3:0] bx [10] = '{4'h1, 4'h4, 4'h2, 4'h8, 4'h3, 4'hc, 4'hf,
                                4'h7, 4'he, 4'h6};
        logic [31:1] ad;
        logic [31:0] dd;
        logic        v;
        for (int h = 0; h < 2; h++) begin
            for (int i = 0; i < 10; i++) begin
                ad = {1'b0, 28'h89abcde, h[0], sel[i][1]};
                dd = 32'(32'h1234_5678 + i);
                bus.addr(6'h03, ad, dd, sel[i][0], 1'b0);
                beat(sel[i][3], sel[i][2], 1'b0, 1'b0,
                     h[0] ? {bx[i], 4'h0} : {4'h0, bx[i]}, v);
                chk("addr", {32'h0, ad, 1'b0}, addr);
                chk("data", {32'h0, dd}, data);
                chk("vld", 64'h1, 64'(v));
                chk("wr", 64'h1, 64'(wr));
                bus.rel_as();
            end
        end
    endtask

    // Forbidden selects, a bad eight byte select and an unknown modifier.
    task automatic t_refuse();
        logic [5:0]  m [4] = '{6'h03, 6'h03, 6'h06, 6'h3f};
        logic [2:0]  s [4] = '{3'b100, 3'b010, 3'b000, 3'b000};
        logic [31:1] ad [4] = '{31'h1, 31'h1, 31'h2, 31'h0};
        bit          ok, eb;
        logic        v;
        for (int i = 0; i < 4; i++) begin
            bus.addr(m[i], ad[i], 32'h0, s[i][0], 1'b1);
            bus.strobe(s[i][2], s[i][1], 1'b0);
            wait_req(ok, v);
            chk("no req", 64'h0, 64'(ok));
            chk("illegal", 64'(i < 3), 64'(illegal));
            bus.done(ok, eb);
            chk("berr", 64'(i < 3), 64'(eb));
            bus.rel_as();
        end
    endtask

    // Address placement of each mode; A40 takes upper bytes from D.
    task automatic t_modes();
        logic [63:0] ax [5] = '{64'h2468, 64'hfe_2468, 64'hfffe_2468,
                                64'h5b_9afe_2468, 64'hcafe_9a5b_fffe_2468};
        logic        v;
        for (int i = 0; i < 5; i++) begin
            bus.addr(6'(i + 1), 31'h7fff_1234, 32'hcafe_9a5b, 1'b0, 1'b1);
            beat(1'b0, 1'b0, 1'b0, 1'b0, 8'h0f, v);
            chk("addr", ax[i], addr);
            chk("mode", 64'(i + 1), 64'(mode));
            chk("wr", 64'h0, 64'(wr));
            bus.rel_as();
        end
    endtask

    // Eight byte block write; the data beat uses the address lines too.
    task automatic t_mblt();
        logic v;
        bus.addr(6'h06, 31'h0246_8ac8, 32'h0, 1'b0, 1'b0);
        beat(1'b0, 1'b0, 1'b0, 1'b0, 8'hff, v);
        chk("eight", 64'h1, 64'(eight));
        chk("vld first", 64'h0, 64'(v));
        bus.put(31'h5555_1234, 32'h89ab_cdef, 1'b1);
        beat(1'b0, 1'b0, 1'b0, 1'b0, 8'hff, v);
        chk("vld", 64'h1, 64'(v));
        chk("data", {31'h5555_1234, 1'b1, 32'h89ab_cdef}, data);
        chk("addr", 64'h048d_1590, addr);
        bus.rel_as();
    endtask

    // Byte(1-2) whose odd strobe lags, passing a forbidden state.
    task automatic t_skew();
        logic v;
        bus.addr(6'h03, 31'h1, 32'h0, 1'b0, 1'b0);
        beat(1'b0, 1'b0, 1'b1, 1'b0, 8'h06, v);
        bus.rel_as();
    endtask

    // A40 write whose data beat is rejected by the local side.
    task automatic t_a40err();
        logic v;
        bus.addr(6'h04, 31'h0, 32'h0, 1'b0, 1'b0);
        beat(1'b0, 1'b0, 1'b0, 1'b0, 8'h0f, v);
        bus.put(31'h7fff_2345, 32'hffff_6789, 1'b0);
        beat(1'b0, 1'b0, 1'b0, 1'b1, 8'h0f, v);
        chk("vld", 64'h1, 64'(v));
        chk("data", {32'h0, 15'h2345, 1'b0, 16'h6789}, data);
        bus.rel_as();
    endtask

    // Reset, idle outputs, then the scenarios in turn.
    initial begin
        {rst, ack, err} = 3'b100;
        repeat (12) @(posedge mclk);
        #1;
        rst = 1'b0;
        chk("idle", 64'h1800,
            64'({req, dtack_oe, berr_oe, dtack_n, berr_n, be, mode}));
        t_refuse();
        t_lanes();
        t_modes();
        t_mblt();
        t_skew();
        t_a40err();
        finish_test();
    end

    // The scenarios take under a thousand cycles; a hang ends the run.
    initial begin
        #250000;
        n_errors++;
        finish_test();
    end
endmodule
